// ==== src/ahp_device.sv ====
// Module: converter-side serial host port
// Contract
// - Mode 00: done low from sample end to result
// - Ready falls on result; select/sync/trigger clears it
// - Sync low at select fall: sync rise starts
// - Clock moves data only while selected
// - First four input bits decode as command
// - Bit 15 captured on first clock fall
// - Later input bits captured on clock falls
// - Input ignored after 16 falls or deselect
// - Output tri-state while deselected; MSB first
// - Output bit 15 valid before first fall
// - Later output bits change on rising edges
// - Output carries previous or queued result
// - Host discards output during write cycles
// - Output released at 16th fall, tri-state converting in modes 01..11
// - Serial input high means hardware default
// - Unused frame sync held high
// - Select fall clears counter; starts if sync high
// - No trigger before eleventh clock rise
module ahp_device #(
   parameter int unsigned RES_W = ahp_pkg::RES_W_WIDE,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // Link
   ahp_link_if.device       link,
   // Result source (conversion engine)
   input  wire logic        result_valid_i,
   output logic             result_ready_o,
   input  wire logic [15:0] result_i,
   input  wire logic        sampling_done_i,
   input  wire logic        conv_done_i,
   input  wire logic [1:0]  conv_mode_i,
   input  wire logic        int_mode_i,
   // Decoded frame
   output logic             cmd_valid_o,
   output logic [3:0]       cmd_o,
   output logic [11:0]      cfg_data_o,
   output logic             trigger_fall_o,
   output logic             conv_clk_edge_o
);
   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [4:0] s1_reg, s2_reg, s3_reg;
   logic       clk_rise, clk_fall, sel_fall, sel_rise, fs_rise, fs_fall;
   logic       trig_fall;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // Link clock idles low; a high reset would fake a clock fall
         s1_reg <= 5'h1E;
         s2_reg <= 5'h1E;
         s3_reg <= 5'h1E;
      end else begin
         s1_reg <= {link.sample_trigger_n, link.serial_in, link.frame_sync,
                    link.dev_sel_n, link.serial_clk};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign clk_rise  =  s2_reg[0] & ~s3_reg[0];
   assign clk_fall  = ~s2_reg[0] &  s3_reg[0];
   assign sel_fall  = ~s2_reg[1] &  s3_reg[1];
   assign sel_rise  =  s2_reg[1] & ~s3_reg[1];
   assign fs_rise   =  s2_reg[2] & ~s3_reg[2];
   assign fs_fall   = ~s2_reg[2] &  s3_reg[2];
   assign trig_fall = ~s2_reg[4] &  s3_reg[4];
   // Clock still serves conversions while deselected
   assign conv_clk_edge_o = clk_fall;
   assign trigger_fall_o  = trig_fall;

   // ---------------------------------------------------------------
   // Result FIFO
   // ---------------------------------------------------------------
   logic        q_valid, q_pop;
   logic [15:0] q_data;

   ahp_fifo #(.WIDTH(16), .DEPTH(DEPTH)) ahp_fifo_inst (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (result_valid_i),
      .in_ready_o  (result_ready_o),
      .in_data_i   (result_i),
      .out_valid_o (q_valid),
      .out_ready_i (q_pop),
      .out_data_o  (q_data)
   );

   // Narrow results pad low bits with ones, host ignores them
   function automatic logic [15:0] fmt(input logic [15:0] r);
      logic [15:0] m;
      m = ahp_pkg::FILL_ONES >> RES_W;
      return (r & ~m) | m;
   endfunction

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   ahp_pkg::ahp_state_t st_reg, st_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [15:0] in_reg, in_next, out_reg, out_next, last_reg, last_next;
   logic        oe_reg, oe_next, fs_wait_reg, fs_wait_next;
   logic        first_reg, first_next, cv_reg, cv_next;
   logic        busy_reg, busy_next, drdy_reg, drdy_next;
   logic        frame_start, sel_n;

   assign sel_n = s2_reg[1];

   always_comb begin
      st_next      = st_reg;
      cnt_next     = cnt_reg;
      in_next      = in_reg;
      out_next     = out_reg;
      last_next    = last_reg;
      oe_next      = oe_reg;
      fs_wait_next = fs_wait_reg;
      first_next   = first_reg;
      cv_next      = 1'b0;
      busy_next    = busy_reg;
      drdy_next    = drdy_reg;
      q_pop        = 1'b0;
      frame_start  = 1'b0;
      // With int_mode_i low, latest result, taken from the queue as it arrives
      if (q_valid && !int_mode_i) begin
         q_pop     = 1'b1;
         last_next = q_data;
      end
      if (sel_fall) begin
         cnt_next     = ahp_pkg::CNT_RST;
         oe_next      = 1'b1;
         fs_wait_next = ~s2_reg[2];
         frame_start  = s2_reg[2];
      end else if (fs_rise && fs_wait_reg && !sel_n) begin
         cnt_next     = ahp_pkg::CNT_RST;
         fs_wait_next = 1'b0;
         frame_start  = 1'b1;
      end
      if (frame_start) begin
         st_next    = ahp_pkg::AHP_ARMED;
         first_next = 1'b1;
         // Output bit 15 presented before any clock fall
         out_next   = fmt((int_mode_i && q_valid) ? q_data : last_reg);
      end else if (sel_n) begin
         st_next = ahp_pkg::AHP_IDLE;
         oe_next = 1'b0;
      end else begin
         unique case (st_reg)
            ahp_pkg::AHP_IDLE: ;
            ahp_pkg::AHP_ARMED: begin
               // Shift begins once sync is high; a sync fall also starts it
               if (fs_fall || s2_reg[2] == 1'b1 && !fs_wait_reg)
                  st_next = ahp_pkg::AHP_SHIFT;
            end
            ahp_pkg::AHP_SHIFT: begin
               if (clk_fall) begin
                  in_next  = {in_reg[14:0], s2_reg[3]};
                  cnt_next = 4'(cnt_reg + 1'b1);
                  first_next = 1'b0;
                  if (cnt_reg == 4'hF) begin
                     st_next = ahp_pkg::AHP_DONE;
                     oe_next = 1'b0;
                     cv_next = 1'b1;
                     // A queue read retires the word it just sent
                     if (int_mode_i && q_valid && in_next[15:12] ==
                         ahp_pkg::CMD_QUEUE_READ) begin
                        q_pop     = 1'b1;
                        last_next = q_data;
                     end
                  end
               end else if (clk_rise && !first_reg) begin
                  out_next = {out_reg[14:0], 1'b1};
               end
            end
            ahp_pkg::AHP_DONE: ;
         endcase
      end
      // Quiet output during conversions in modes 01..11
      if (busy_reg && conv_mode_i != ahp_pkg::MODE_00)
         oe_next = 1'b0;
      // Conversion-done level for mode 00
      if (sampling_done_i) busy_next = 1'b1;
      if (conv_done_i)     busy_next = 1'b0;
      // Ready flag: new result sets, which wins over the clears
      if (sel_fall || fs_rise || trig_fall) drdy_next = 1'b0;
      // Set on arrival only, so a clear sticks until the next result
      if (int_mode_i && result_valid_i && result_ready_o)
         drdy_next = 1'b1;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg      <= ahp_pkg::AHP_IDLE;
         cnt_reg     <= ahp_pkg::CNT_RST;
         in_reg      <= ahp_pkg::WORD_RST;
         out_reg     <= ahp_pkg::FILL_ONES;
         last_reg    <= ahp_pkg::WORD_RST;
         oe_reg      <= 1'b0;
         fs_wait_reg <= 1'b0;
         first_reg   <= 1'b0;
         cv_reg      <= 1'b0;
         busy_reg    <= 1'b0;
         drdy_reg    <= 1'b0;
      end else begin
         st_reg      <= st_next;
         cnt_reg     <= cnt_next;
         in_reg      <= in_next;
         out_reg     <= out_next;
         last_reg    <= last_next;
         oe_reg      <= oe_next;
         fs_wait_reg <= fs_wait_next;
         first_reg   <= first_next;
         cv_reg      <= cv_next;
         busy_reg    <= busy_next;
         drdy_reg    <= drdy_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign link.serial_out_o  = out_reg[15];
   assign link.serial_out_oe = oe_reg;
   assign link.data_ready_n  = int_mode_i ? ~drdy_reg
                             : ~(busy_reg && conv_mode_i == ahp_pkg::MODE_00);
   assign cmd_valid_o = cv_reg;
   assign cmd_o       = in_reg[ahp_pkg::CMD_MSB:ahp_pkg::CMD_LSB];
   assign cfg_data_o  = in_reg[11:0];
endmodule // ahp_device

// ==== shared/ahp_pkg.sv ====
// Package: constants and types shared by both ends of the host serial port
package ahp_pkg;
   // ---------------------------------------------------------------
   // Frame geometry
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned CMD_BITS     = 4;
   localparam int unsigned CFG_BITS     = 12;
   localparam int unsigned CMD_MSB      = 15;
   localparam int unsigned CMD_LSB      = 12;
   localparam int unsigned RES_W_WIDE   = 14;
   localparam int unsigned TRIG_MIN_EDGE = 11;
   localparam logic [3:0]  CNT_RST      = 4'h0;
   localparam logic [15:0] WORD_RST     = 16'h0000;
   localparam logic [15:0] FILL_ONES    = 16'hFFFF;
   // ---------------------------------------------------------------
   // Commands carried in bits 15..12 of the input word
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_SELECT       = 4'h0;
   localparam logic [3:0] CMD_CONVERT      = 4'hB;
   localparam logic [3:0] CMD_QUEUE_READ   = 4'hE;
   localparam logic [3:0] WRITE_CONFIG_CMD = 4'hA;
   // ---------------------------------------------------------------
   // Conversion modes
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_00 = 2'h0;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned SYS_CLK_MHZ  = 100;
   localparam int unsigned LINK_HALF_NS = 200;
   localparam int unsigned LINK_HALF_CYC =
      (LINK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  DIV_RST      = 8'h00;

   typedef enum logic [1:0] {
      AHP_IDLE,
      AHP_ARMED,
      AHP_SHIFT,
      AHP_DONE
   } ahp_state_t;
endpackage

// ==== shared/ahp_link_if.sv ====
// Interface: serial link pins between host and converter port
interface ahp_link_if;
   logic serial_clk;
   logic frame_sync;
   logic dev_sel_n;
   logic serial_in;
   logic sample_trigger_n;
   logic serial_out_o;
   logic serial_out_oe;
   logic data_ready_n;
   logic serial_out;

   assign serial_out = serial_out_oe ? serial_out_o : 1'b1;

   modport device (
      input  serial_clk,
      input  frame_sync,
      input  dev_sel_n,
      input  serial_in,
      input  sample_trigger_n,
      output serial_out_o,
      output serial_out_oe,
      output data_ready_n
   );
   modport host (
      output serial_clk,
      output frame_sync,
      output dev_sel_n,
      output serial_in,
      output sample_trigger_n,
      input  serial_out,
      input  data_ready_n
   );
endinterface

// ==== src/ahp_fifo.sv ====
// Module: small flip-flop FIFO with valid/ready on both sides
module ahp_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_b_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   assign in_ready_o  = (cnt_reg < (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem_reg[rd_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_next = (AW+1)'(cnt_reg + {{AW{1'b0}}, push}
                 - {{AW{1'b0}}, pop});
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
endmodule // ahp_fifo

// ==== src/ahp_host.sv ====
// Module: host-side master driving the converter's serial link
module ahp_host (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // Request
   input  wire logic        req_valid_i,
   output logic             req_ready_o,
   input  wire logic [15:0] req_word_i,
   input  wire logic        use_sync_i,
   input  wire logic        trig_req_i,
   // Answer
   output logic             rsp_valid_o,
   output logic [15:0]      rsp_word_o,
   output logic             data_ready_o,
   // Link
   ahp_link_if.host         link
);
   typedef enum logic [1:0] {H_IDLE, H_SYNC, H_RUN, H_END} ahp_hst_t;
   ahp_hst_t    st_reg, st_next;
   logic [7:0]  div_reg, div_next;
   logic [4:0]  edg_reg, edg_next;
   logic [15:0] tx_reg, tx_next, rx_reg, rx_next;
   logic        sclk_reg, sclk_next, sel_reg, sel_next, fs_reg, fs_next;
   logic        wr_reg, wr_next, rv_reg, rv_next, tr_reg, tr_next;
   logic [1:0]  so_sync_reg, dr_sync_reg;
   logic        tick;

   assign tick = (div_reg == 8'(ahp_pkg::LINK_HALF_CYC - 1));

   always_comb begin
      st_next   = st_reg;
      div_next  = tick ? ahp_pkg::DIV_RST : 8'(div_reg + 1'b1);
      edg_next  = edg_reg;
      tx_next   = tx_reg;
      rx_next   = rx_reg;
      sclk_next = sclk_reg;
      sel_next  = sel_reg;
      fs_next   = fs_reg;
      wr_next   = wr_reg;
      rv_next   = 1'b0;
      tr_next   = 1'b1;
      unique case (st_reg)
         H_IDLE: if (req_valid_i && tick) begin
            tx_next  = req_word_i;
            wr_next  = req_word_i[15:12] == ahp_pkg::WRITE_CONFIG_CMD;
            sel_next = 1'b0;
            fs_next  = ~use_sync_i;
            edg_next = '0;
            st_next  = use_sync_i ? H_SYNC : H_RUN;
         end
         H_SYNC: if (tick) begin
            // Rise starts the cycle; bit 15 waits for the fall
            fs_next = ~fs_reg;
            if (fs_reg) st_next = H_RUN;
         end
         H_RUN: if (tick) begin
            sclk_next = ~sclk_reg;
            edg_next  = 5'(edg_reg + 1'b1);
            if (sclk_reg) begin
               // Falling edge: device samples, host samples output
               rx_next = {rx_reg[14:0], so_sync_reg[1]};
            end else if (edg_reg != '0) begin
               tx_next = {tx_reg[14:0], 1'b0};
            end
            if (edg_reg == 5'(2 * ahp_pkg::FRAME_BITS - 1)) st_next = H_END;
         end
         H_END: if (tick) begin
            sel_next = 1'b1;
            fs_next  = 1'b1;
            tx_next  = ahp_pkg::FILL_ONES;
            rv_next  = ~wr_reg;
            st_next  = H_IDLE;
         end
      endcase
      // First trigger only after the eleventh clock rise
      if (trig_req_i && (st_reg == H_IDLE ||
          edg_reg >= 5'(2 * ahp_pkg::TRIG_MIN_EDGE - 1)))
         tr_next = 1'b0;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg      <= H_IDLE;
         div_reg     <= ahp_pkg::DIV_RST;
         edg_reg     <= '0;
         tx_reg      <= ahp_pkg::FILL_ONES;
         rx_reg      <= ahp_pkg::WORD_RST;
         sclk_reg    <= 1'b0;
         sel_reg     <= 1'b1;
         fs_reg      <= 1'b1;
         wr_reg      <= 1'b0;
         rv_reg      <= 1'b0;
         tr_reg      <= 1'b1;
         so_sync_reg <= 2'h3;
         dr_sync_reg <= 2'h3;
      end else begin
         st_reg      <= st_next;
         div_reg     <= div_next;
         edg_reg     <= edg_next;
         tx_reg      <= tx_next;
         rx_reg      <= rx_next;
         sclk_reg    <= sclk_next;
         sel_reg     <= sel_next;
         fs_reg      <= fs_next;
         wr_reg      <= wr_next;
         rv_reg      <= rv_next;
         tr_reg      <= tr_next;
         so_sync_reg <= {so_sync_reg[0], link.serial_out};
         dr_sync_reg <= {dr_sync_reg[0], link.data_ready_n};
      end
   end

   assign req_ready_o           = (st_reg == H_IDLE) && tick;
   assign rsp_valid_o           = rv_reg;
   assign rsp_word_o            = rx_reg;
   assign data_ready_o          = ~dr_sync_reg[1];
   assign link.serial_clk       = sclk_reg;
   assign link.dev_sel_n        = sel_reg;
   assign link.frame_sync       = fs_reg;
   assign link.serial_in        = tx_reg[15];
   assign link.sample_trigger_n = tr_reg;
endmodule // ahp_host

// ==== tb/ahp_link_checker.sv ====
// Checker: concurrent assertions on the host serial link pins
module ahp_link_checker (
   // ------------------------------------------------------------
   // Clock and reset
   // ------------------------------------------------------------
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // ------------------------------------------------------------
   // Link pins
   // ------------------------------------------------------------
   input wire logic serial_clk,
   input wire logic frame_sync,
   input wire logic dev_sel_n,
   input wire logic serial_in,
   input wire logic sample_trigger_n,
   input wire logic serial_out_o,
   input wire logic serial_out_oe,
   input wire logic data_ready_n
);
   logic       clk_prev_reg;
   logic       clk_prev_next;
   logic [4:0] fall_cnt_reg;
   logic [4:0] fall_cnt_next;
   logic       fall_evt;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   // Falls of the link clock seen within one frame
   always_comb begin
      fall_evt      = clk_prev_reg & ~serial_clk;
      clk_prev_next = serial_clk;
      fall_cnt_next = fall_cnt_reg;
      if (dev_sel_n) begin
         fall_cnt_next = 5'h00;
      end else if (fall_evt) begin
         fall_cnt_next = fall_cnt_reg + 5'h01;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_prev_reg <= 1'b0;
         fall_cnt_reg <= 5'h00;
      end else begin
         clk_prev_reg <= clk_prev_next;
         fall_cnt_reg <= fall_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Six cycles cover the two input flops of the device
   tri_idle_a: assert property (dev_sel_n [*6] |-> !serial_out_oe)
      else $error("output driven while deselected");
   out_driven_a: assert property (
      fall_evt && !dev_sel_n && fall_cnt_reg < 5'h10 |-> serial_out_oe)
      else $error("output not driven at a clock fall");
   out_shift_a: assert property (
      $changed(serial_out_o) && serial_out_oe && $past(serial_out_oe)
      && fall_cnt_reg != 5'h00 |-> serial_clk)
      else $error("output bit changed while link clock low");
   oe_release_a: assert property (
      fall_evt && fall_cnt_reg == 5'h0F |-> ##[1:8] !serial_out_oe)
      else $error("output not released after 16th fall");
   in_stable_a: assert property (
      fall_evt && !dev_sel_n |-> $stable(serial_in))
      else $error("input bit moved at capture fall");
   frame_len_a: assert property (
      $rose(dev_sel_n) |-> fall_cnt_reg == 5'h10)
      else $error("frame not 16 clock falls");
   sel_clear_a: assert property (
      $fell(dev_sel_n) |-> ##[1:6] data_ready_n)
      else $error("ready not cleared by select");
   sync_clear_a: assert property (
      $rose(frame_sync) |-> ##[1:6] data_ready_n)
      else $error("ready not cleared by frame sync");
   trig_clear_a: assert property (
      $fell(sample_trigger_n) |-> ##[1:6] data_ready_n)
      else $error("ready not cleared by trigger");

   frame_end_c: cover property (fall_evt && fall_cnt_reg == 5'h0F);
   ready_fall_c: cover property ($fell(data_ready_n));
   trig_fall_c: cover property ($fell(sample_trigger_n));
endmodule // ahp_link_checker

// ==== tb/adc_serial_host_port_tb_top.sv ====
// Testbench: both ends of the host serial port joined over the link
module adc_serial_host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned RES_W = ahp_pkg::RES_W_WIDE;
   localparam int unsigned DEPTH = 16;

   logic        sys_clk_i = 1'b0, rst_b_i = 1'b0;
   logic        res_valid = 1'b0, res_ready, smp_done = 1'b0;
   logic [15:0] res_data = 16'h0000, rsp_word, req_word = 16'h0000;
   logic        conv_done = 1'b0, int_mode = 1'b1, cmd_valid;
   logic [1:0]  conv_mode = ahp_pkg::MODE_00;
   logic [3:0]  cmd;
   logic [11:0] cfg_data;
   logic        trig_fall, req_valid = 1'b0, req_ready, use_sync = 1'b0;
   logic        trig_req = 1'b0, rsp_valid, data_ready;
   int          miscompares = 0, checked = 0;

   always #5 sys_clk_i = ~sys_clk_i;

   ahp_link_if ahp_link_if_inst ();
   ahp_device #(.RES_W(RES_W), .DEPTH(DEPTH)) ahp_device_inst (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(ahp_link_if_inst),
      .result_valid_i(res_valid), .result_ready_o(res_ready),
      .result_i(res_data), .sampling_done_i(smp_done),
      .conv_done_i(conv_done), .conv_mode_i(conv_mode),
      .int_mode_i(int_mode), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
      .cfg_data_o(cfg_data), .trigger_fall_o(trig_fall),
      .conv_clk_edge_o());
   ahp_host ahp_host_inst (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid),
      .req_ready_o(req_ready), .req_word_i(req_word),
      .use_sync_i(use_sync), .trig_req_i(trig_req),
      .rsp_valid_o(rsp_valid), .rsp_word_o(rsp_word),
      .data_ready_o(data_ready), .link(ahp_link_if_inst));
   ahp_link_checker ahp_link_checker_inst (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .serial_clk(ahp_link_if_inst.serial_clk),
      .frame_sync(ahp_link_if_inst.frame_sync),
      .dev_sel_n(ahp_link_if_inst.dev_sel_n),
      .serial_in(ahp_link_if_inst.serial_in),
      .sample_trigger_n(ahp_link_if_inst.sample_trigger_n),
      .serial_out_o(ahp_link_if_inst.serial_out_o),
      .serial_out_oe(ahp_link_if_inst.serial_out_oe),
      .data_ready_n(ahp_link_if_inst.data_ready_n));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   function automatic logic [15:0] res_word(input int i);
      return 16'h8421 ^ (16'(i) * 16'h0357);
   endfunction

   // Low positions past the result width read as ones
   function automatic logic [15:0] exp_word(input logic [15:0] w);
      logic [15:0] mask;
      mask = ahp_pkg::FILL_ONES >> RES_W;
      return (w & ~mask) | mask;
   endfunction

   // One whole frame; the request is held until ready is seen high
   task automatic send_frame(input logic [15:0] word, input logic sync,
                             input logic want_rsp);
      int   n;
      logic got_cmd;
      logic got_rsp;
      got_cmd = 1'b0;
      got_rsp = 1'b0;
      @(posedge sys_clk_i);
      req_word  <= word;
      use_sync  <= sync;
      req_valid <= 1'b1;
      @(negedge sys_clk_i);
      for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
      req_valid <= 1'b0;
      // Write frames never answer, so they run the whole window
      for (n = 0; n < 1200 && !(got_cmd && got_rsp); n++) begin
         @(negedge sys_clk_i);
         if (cmd_valid === 1'b1) got_cmd = 1'b1;
         if (rsp_valid === 1'b1) got_rsp = 1'b1;
      end
      check(got_cmd, "no command decoded");
      check(got_rsp === want_rsp, "answer pulse wrong");
      check(cmd === word[15:12], "command code");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check(ahp_link_if_inst.serial_out_oe === 1'b0, "oe after reset");
      check(ahp_link_if_inst.data_ready_n === 1'b1, "ready after reset");
      check(ahp_link_if_inst.frame_sync === 1'b1, "sync idle");
      check(ahp_link_if_inst.serial_in === 1'b1, "input idle");
   endtask

   task automatic t_fill();
      int n;
      n = 0;
      @(posedge sys_clk_i);
      res_valid <= 1'b1;
      res_data  <= res_word(0);
      forever begin
         @(negedge sys_clk_i);
         if (res_ready !== 1'b1 || n > 40) break;
         @(posedge sys_clk_i);
         n++;
         res_data <= res_word(n);
      end
      @(posedge sys_clk_i);
      res_valid <= 1'b0;
      check(n == DEPTH, "buffer did not refuse at depth");
   endtask

   // Alternates sync start and select start while draining
   task automatic t_drain();
      for (int i = 0; i < DEPTH; i++) begin
         send_frame({ahp_pkg::CMD_QUEUE_READ, 12'h000}, i[0], 1'b1);
         check(rsp_word === exp_word(res_word(i)), "queued word");
      end
      @(negedge sys_clk_i);
      check(res_ready === 1'b1, "buffer not empty after drain");
   endtask

   task automatic t_cmds();
      send_frame({ahp_pkg::CMD_SELECT, 12'h000}, 1'b0, 1'b1);
      send_frame({ahp_pkg::CMD_CONVERT, 12'h000}, 1'b1, 1'b1);
      send_frame({ahp_pkg::WRITE_CONFIG_CMD, 12'h5A3}, 1'b1, 1'b0);
      check(cfg_data === 12'h5A3, "config data");
   endtask

   task automatic t_ready();
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk_i);
      res_valid <= 1'b1;
      res_data  <= res_word(DEPTH);
      @(posedge sys_clk_i);
      res_valid <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      check(ahp_link_if_inst.data_ready_n === 1'b0, "ready not set");
      check(data_ready === 1'b1, "host ready flag");
      trig_req <= 1'b1;
      for (int n = 0; n < 100 && !seen; n++) begin
         @(negedge sys_clk_i);
         if (trig_fall === 1'b1) seen = 1'b1;
      end
      repeat (10) @(posedge sys_clk_i);
      trig_req <= 1'b0;
      check(seen, "trigger fall not seen");
      check(ahp_link_if_inst.data_ready_n === 1'b1, "ready kept");
   endtask

   task automatic t_eoc();
      @(posedge sys_clk_i);
      int_mode <= 1'b0;
      smp_done <= 1'b1;
      @(posedge sys_clk_i);
      smp_done <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      check(ahp_link_if_inst.data_ready_n === 1'b0, "done not low");
      repeat (20) @(posedge sys_clk_i);
      check(ahp_link_if_inst.data_ready_n === 1'b0, "done not held");
      conv_done <= 1'b1;
      @(posedge sys_clk_i);
      conv_done <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      check(ahp_link_if_inst.data_ready_n === 1'b1, "done not ended");
      // Outside mode 00 the pin gives no done level
      conv_mode <= 2'h1;
      smp_done  <= 1'b1;
      @(posedge sys_clk_i);
      smp_done <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      check(ahp_link_if_inst.data_ready_n === 1'b1, "done in mode 01");
      conv_done <= 1'b1;
      @(posedge sys_clk_i);
      conv_done <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      t_reset();
      t_fill();
      t_drain();
      t_cmds();
      t_ready();
      t_eoc();
      give_verdict();
   end

   // About 14k cycles of frames are expected; allow nearly three times that
   initial begin
      #400us;
      miscompares++;
      $display("FAIL %0t watchdog expired", $time);
      give_verdict();
   end
endmodule // adc_serial_host_port_tb_top
